// ---- ccd_pkg.sv ----
// Shared constants, types and field helpers for the chop and detect bank
package ccd_pkg;

  localparam int unsigned NCH = 2;

  // Word indices; byte address is four times the index
  localparam logic [4:0] IDX_RSVD = 5'h05;
  localparam logic [4:0] IDX_CFG  = 5'h06;
  localparam logic [4:0] IDX_THH  = 5'h07;
  localparam logic [4:0] IDX_THL  = 5'h08;
  localparam logic [4:0] IDX_STAT = 5'h10;
  localparam logic [4:0] IDX_MASK = 5'h11;

  // Configuration and lower-threshold word field positions
  localparam int unsigned MODE_POS   = 0;
  localparam int unsigned WIN_LSB    = 1;
  localparam int unsigned HITS_LSB   = 4;
  localparam int unsigned ALLCH_POS  = 7;
  localparam int unsigned CHOP_POS   = 8;
  localparam int unsigned DLY_LSB    = 9;
  localparam int unsigned THL_LSB    = 8;
  localparam int unsigned DCB_LSB    = 0;

  // Reset values and writable masks
  localparam logic [15:0] RSVD_RST  = 16'h0000;
  localparam logic [15:0] CFG_RST   = 16'h0600;
  localparam logic [15:0] THH_RST   = 16'h0000;
  localparam logic [15:0] THL_RST   = 16'h0000;
  localparam logic [15:0] THL_WMASK = 16'hff0f;
  localparam logic [1:0]  IRQ_RST   = 2'h0;

  // Status and mask bit positions
  localparam int unsigned ST_DETECT = 0;
  localparam int unsigned ST_SETTLE = 1;

  typedef struct packed {
    logic [3:0] settle_delay;
    logic       chop_enable;
    logic       detect_all_channels;
    logic [2:0] detect_hit_count;
    logic [2:0] detect_window_length;
    logic       detect_mode_enable;
  } ccd_cfg_s;

  typedef struct packed {
    logic [16:0] settle_cycles;
    logic [7:0]  hit_target;
    logic [11:0] window_len;
  } ccd_lim_s;

  function automatic ccd_cfg_s cfg_unpack(input logic [15:0] w);
    cfg_unpack.settle_delay         = w[DLY_LSB+:4];
    cfg_unpack.chop_enable          = w[CHOP_POS];
    cfg_unpack.detect_all_channels  = w[ALLCH_POS];
    cfg_unpack.detect_hit_count     = w[HITS_LSB+:3];
    cfg_unpack.detect_window_length = w[WIN_LSB+:3];
    cfg_unpack.detect_mode_enable   = w[MODE_POS];
  endfunction

  function automatic logic [11:0] window_of(input logic [2:0] c);
    case (c)
      3'h0:    window_of = 12'd128;
      3'h1:    window_of = 12'd256;
      3'h2:    window_of = 12'd512;
      3'h3:    window_of = 12'd768;
      3'h4:    window_of = 12'd1280;
      3'h5:    window_of = 12'd1792;
      3'h6:    window_of = 12'd2560;
      default: window_of = 12'd3584;
    endcase
  endfunction

  // Byte-lane merge of a 16-bit register under a write mask
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] nw,
                                             input logic [3:0]  be,
                                             input logic [15:0] wm);
    logic [15:0] sel;
    sel = {{8{be[1]}}, {8{be[0]}}} & wm;
    lane_merge = (old & ~sel) | (nw & sel);
  endfunction

  function automatic logic [23:0] magnitude(input logic [23:0] s);
    magnitude = s[23] ? 24'(~s + 24'h1) : s;
  endfunction

endpackage

// ---- ccd_decode.sv ----
// Field decoder: turns configuration codes into counts
`timescale 1ns/1ps
module ccd_decode
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire ccd_pkg::ccd_cfg_s cfg,
  output ccd_pkg::ccd_lim_s      lim
);

  always_comb
  begin
    lim.settle_cycles = 17'h1 << (5'(cfg.settle_delay) + 5'h1); // [RQ1]
    lim.hit_target    = 8'h1 << cfg.detect_hit_count; // [RQ3]
    lim.window_len    = ccd_pkg::window_of(cfg.detect_window_length); // [RQ4]
  end

  a_window_table: assert property ( // [RQ4]
    @(posedge clk) disable iff (!nrst)
    (cfg.detect_window_length == 3'h3) |-> (lim.window_len == 12'd768))
    else $error("window code 3 is not 768");

  a_delay_span: assert property ( // [RQ1]
    @(posedge clk) disable iff (!nrst)
    (cfg.settle_delay == 4'hf) |-> (lim.settle_cycles == 17'h10000))
    else $error("delay code 15 is not 65536");

endmodule

// ---- ccd_irq.sv ----
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
module ccd_irq
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [1:0] evt,
  input  wire logic       clr_we,
  input  wire logic       mask_we,
  input  wire logic [1:0] wdata,
  output logic [1:0]      status_q,
  output logic [1:0]      mask_q,
  output logic            irq
);

  logic [1:0] status_d;
  logic [1:0] mask_d;

  // Set beats clear so an event landing on a clear write is kept
  always_comb
  begin
    status_d = (status_q & ~(clr_we ? wdata : 2'h0)) | evt;
    mask_d   = mask_we ? wdata : mask_q;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_q <= ccd_pkg::IRQ_RST;
      mask_q   <= ccd_pkg::IRQ_RST;
    end
    else
    begin
      status_q <= status_d;
      mask_q   <= mask_d;
    end
  end

  assign irq = |(status_q & mask_q);

  a_set_wins: assert property (
    @(posedge clk) disable iff (!nrst)
    (evt[0] && clr_we && wdata[0]) |=> status_q[0])
    else $error("event lost on clear");

endmodule

// ---- ccd_regs.sv ----
// Chop and current-detect register bank with detection engine
`timescale 1ns/1ps
// How it works
// [RQ1] Bit 8 enables chop; bits 12:9 give settle wait of 2^(code+1) ticks.
// [RQ2] Bit 7 zero: any channel triggers; one: all channels must exceed.
// [RQ3] Bits 6:4 set required exceedance count as two to the code.
// [RQ4] Bits 3:1 select window of 128 to 3584 conversions, reset 128.
// [RQ5] Bit 0 turns current-detect mode on; off after reset.
// [RQ6] Word 7h holds upper sixteen threshold bits, read-write, reset zero.
// [RQ7] Software writes zeros to word 5h and configuration bits 15:13.
// [RQ8] Configuration word 6h resets to 0600h, delay code three.
// [RQ9] Word 8h bits 15:8 hold the low eight threshold bits.
// [RQ10] Detection compares sample magnitude against the joined 24-bit threshold.
module ccd_regs
(
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic [6:0]                    address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [31:0]                   writedata,
  input  wire logic [3:0]                    byteenable,
  output logic [31:0]                        readdata,
  output logic                               waitrequest,
  input  wire logic                          mod_tick,
  input  wire logic                          chop_start,
  input  wire logic                          sample_valid,
  input  wire logic [ccd_pkg::NCH-1:0][23:0] sample,
  output ccd_pkg::ccd_cfg_s                  cfg,
  output logic [23:0]                        threshold,
  output logic [3:0]                         dc_block,
  output logic                               chop_settling,
  output logic                               detect_pulse,
  output logic                               irq
);

  logic [15:0] rsvd_q, rsvd_d;
  logic [15:0] cfg_q, cfg_d;
  logic [15:0] thh_q, thh_d;
  logic [15:0] thl_q, thl_d;
  logic        ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic [4:0]  idx;
  logic        wr_en;
  logic [1:0]  status_q;
  logic [1:0]  mask_q;
  ccd_pkg::ccd_lim_s lim;

  // One wait cycle: decode and fetch, then complete on the next edge
  assign idx         = address[6:2];
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_en       = write & ack_q;
  assign readdata    = rd_q;

  always_comb
  begin
    ack_d = (read | write) & ~ack_q;
    rd_d  = rd_q;
    if (read && !ack_q)
    begin
      case (idx)
        ccd_pkg::IDX_RSVD: rd_d = {16'h0000, rsvd_q};
        ccd_pkg::IDX_CFG:  rd_d = {16'h0000, cfg_q};
        ccd_pkg::IDX_THH:  rd_d = {16'h0000, thh_q};
        ccd_pkg::IDX_THL:  rd_d = {16'h0000, thl_q};
        ccd_pkg::IDX_STAT: rd_d = {30'h0, status_q};
        ccd_pkg::IDX_MASK: rd_d = {30'h0, mask_q};
        default:           rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    rsvd_d = rsvd_q;
    cfg_d  = cfg_q;
    thh_d  = thh_q;
    thl_d  = thl_q;
    if (wr_en)
    begin
      case (idx)
        ccd_pkg::IDX_RSVD:
          rsvd_d = ccd_pkg::lane_merge(rsvd_q, writedata[15:0],
                                       byteenable, 16'hffff);
        ccd_pkg::IDX_CFG:
          cfg_d = ccd_pkg::lane_merge(cfg_q, writedata[15:0],
                                      byteenable, 16'hffff);
        ccd_pkg::IDX_THH: // [RQ6]
          thh_d = ccd_pkg::lane_merge(thh_q, writedata[15:0],
                                      byteenable, 16'hffff);
        ccd_pkg::IDX_THL: // [RQ9]
          thl_d = ccd_pkg::lane_merge(thl_q, writedata[15:0],
                                      byteenable, ccd_pkg::THL_WMASK);
        default:
          rsvd_d = rsvd_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rsvd_q <= ccd_pkg::RSVD_RST;
      cfg_q  <= ccd_pkg::CFG_RST; // [RQ8]
      thh_q  <= ccd_pkg::THH_RST;
      thl_q  <= ccd_pkg::THL_RST;
      ack_q  <= 1'b0;
      rd_q   <= 32'h0000_0000;
    end
    else
    begin
      rsvd_q <= rsvd_d;
      cfg_q  <= cfg_d;
      thh_q  <= thh_d;
      thl_q  <= thl_d;
      ack_q  <= ack_d;
      rd_q   <= rd_d;
    end
  end

  // Reserved bits are stored as written; writing zeros is up to software
  assign cfg       = ccd_pkg::cfg_unpack(cfg_q); // [RQ7]
  assign threshold = {thh_q, thl_q[ccd_pkg::THL_LSB+:8]}; // [RQ10]
  assign dc_block  = thl_q[ccd_pkg::DCB_LSB+:4];

  ccd_decode u_decode
  (
    .clk  (clk),
    .nrst (nrst),
    .cfg  (cfg),
    .lim  (lim)
  );

  // Chop settle timer, counted in modulator ticks
  logic [16:0] chop_cnt_q, chop_cnt_d;
  logic        settle_evt;

  always_comb
  begin
    chop_cnt_d = chop_cnt_q;
    settle_evt = 1'b0;
    if (!cfg.chop_enable) // [RQ1]
      chop_cnt_d = 17'h0;
    else if (chop_start)
      chop_cnt_d = lim.settle_cycles; // [RQ1]
    else if (mod_tick && chop_cnt_q != 17'h0)
    begin
      chop_cnt_d = chop_cnt_q - 17'h1;
      settle_evt = (chop_cnt_q == 17'h1);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      chop_cnt_q <= 17'h0;
    else
      chop_cnt_q <= chop_cnt_d;
  end

  assign chop_settling = (chop_cnt_q != 17'h0);

  // Detection engine: one decision per conversion
  logic [11:0]            win_q, win_d;
  logic [7:0]             hit_q, hit_d;
  logic                   done_q, done_d;
  logic                   det_q;
  logic                   detect_evt;
  logic [ccd_pkg::NCH-1:0] exceed;
  logic                   hit;
  logic                   win_end;

  always_comb
  begin
    for (int i = 0; i < ccd_pkg::NCH; i++)
      exceed[i] = ccd_pkg::magnitude(sample[i]) > threshold; // [RQ10]
    hit = cfg.detect_all_channels ? &exceed : |exceed; // [RQ2]
    win_end = (win_q == 12'(lim.window_len - 12'h1)); // [RQ4]
  end

  always_comb
  begin
    win_d      = win_q;
    hit_d      = hit_q;
    done_d     = done_q;
    detect_evt = 1'b0;
    if (!cfg.detect_mode_enable) // [RQ5]
    begin
      win_d  = 12'h0;
      hit_d  = 8'h0;
      done_d = 1'b0;
    end
    else if (sample_valid)
    begin
      if (hit && !done_q && hit_q < 8'h80)
        hit_d = hit_q + 8'h1;
      if (hit && !done_q && hit_d >= lim.hit_target) // [RQ3]
      begin
        detect_evt = 1'b1;
        done_d     = 1'b1;
      end
      // One detection per window; a new window starts clean
      if (win_end)
      begin
        win_d  = 12'h0;
        hit_d  = 8'h0;
        done_d = 1'b0;
      end
      else
        win_d = win_q + 12'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      win_q  <= 12'h0;
      hit_q  <= 8'h0;
      done_q <= 1'b0;
      det_q  <= 1'b0;
    end
    else
    begin
      win_q  <= win_d;
      hit_q  <= hit_d;
      done_q <= done_d;
      det_q  <= detect_evt;
    end
  end

  assign detect_pulse = det_q;

  ccd_irq u_irq
  (
    .clk      (clk),
    .nrst     (nrst),
    .evt      ({settle_evt, detect_evt}),
    .clr_we   (wr_en && idx == ccd_pkg::IDX_STAT && byteenable[0]),
    .mask_we  (wr_en && idx == ccd_pkg::IDX_MASK && byteenable[0]),
    .wdata    (writedata[1:0]),
    .status_q (status_q),
    .mask_q   (mask_q),
    .irq      (irq)
  );

  a_cfg_reset_val: assert property ( // [RQ8]
    @(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> (cfg_q == 16'h0600 && cfg.settle_delay == 4'h3))
    else $error("configuration reset value wrong");

  a_thh_write_back: assert property ( // [RQ6]
    @(posedge clk) disable iff (!nrst)
    (wr_en && idx == ccd_pkg::IDX_THH && byteenable == 4'hf)
      |=> (threshold[23:8] == $past(writedata[15:0])))
    else $error("upper threshold not stored");

  a_thl_read_back: assert property ( // [RQ9]
    @(posedge clk) disable iff (!nrst)
    (read && !ack_q && idx == ccd_pkg::IDX_THL)
      |=> (readdata[7:4] == 4'h0 && readdata[15:8] == threshold[7:0]))
    else $error("lower threshold word wrong");

  a_settle_load: assert property ( // [RQ1]
    @(posedge clk) disable iff (!nrst)
    (cfg.chop_enable && chop_start)
      |=> (chop_cnt_q == $past(lim.settle_cycles)))
    else $error("settle delay not loaded");

  a_mode_off: assert property ( // [RQ5]
    @(posedge clk) disable iff (!nrst)
    !cfg.detect_mode_enable |=> (hit_q == 8'h0 && !detect_pulse))
    else $error("detection active while off");

  a_all_policy: assert property ( // [RQ2]
    @(posedge clk) disable iff (!nrst)
    (cfg.detect_mode_enable && sample_valid && cfg.detect_all_channels
      && !(&exceed)) |=> (hit_q <= $past(hit_q)))
    else $error("hit counted without all channels");

  a_any_hit_count: assert property ( // [RQ10]
    @(posedge clk) disable iff (!nrst)
    (cfg.detect_mode_enable && sample_valid && !cfg.detect_all_channels
      && (|exceed) && !done_q && !win_end && hit_q < 8'h80)
      |=> (hit_q == $past(hit_q) + 8'h1))
    else $error("exceedance not counted");

  a_hit_reached: assert property ( // [RQ3]
    @(posedge clk) disable iff (!nrst)
    detect_evt |-> (hit_d >= lim.hit_target) ##1 detect_pulse)
    else $error("detection before hit count");

endmodule

// ---- tb_ccd_regs.sv ----
// Self-checking bench for the chop and current-detect register bank
`timescale 1ns/1ps
module tb_ccd_regs;
  logic                          clk;
  logic                          nrst;
  logic [6:0]                    address;
  logic                          read;
  logic                          write;
  logic [31:0]                   writedata;
  logic [3:0]                    byteenable;
  logic [31:0]                   readdata;
  logic                          waitrequest;
  logic                          mod_tick;
  logic                          chop_start;
  logic                          sample_valid;
  logic [ccd_pkg::NCH-1:0][23:0] sample;
  ccd_pkg::ccd_cfg_s             cfg;
  logic [23:0]                   threshold;
  logic [3:0]                    dc_block;
  logic                          chop_settling;
  logic                          detect_pulse;
  logic                          irq;
  int                            miscompares;
  int                            tests_run;

  ccd_regs i_ccd_regs (
    .clk(clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .mod_tick(mod_tick),
    .chop_start(chop_start), .sample_valid(sample_valid),
    .sample(sample), .cfg(cfg), .threshold(threshold),
    .dc_block(dc_block), .chop_settling(chop_settling),
    .detect_pulse(detect_pulse), .irq(irq));

  always #2.5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Waitrequest and readdata are taken at the rising edge itself, before
  // the design's registers move; the request drops only after that edge
  task automatic bus(input logic wr, input logic [6:0] a,
                     input logic [15:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= {16'h0000, d};
    byteenable <= be;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 100);
    chk({31'h0, waitrequest}, 32'h0, "bus answer");
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, 4'hf, q);
    chk(q, exp, "read data");
  endtask

  task automatic samp(input logic [23:0] s0, input logic [23:0] s1,
                      input logic exp);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample[0] <= s0;
    sample[1] <= s1;
    @(posedge clk);
    sample_valid <= 1'b0;
    @(negedge clk);
    chk({31'h0, detect_pulse}, {31'h0, exp}, "detect pulse");
  endtask

  task automatic pulse(input logic is_tick);
    @(posedge clk);
    if (is_tick)
      mod_tick <= 1'b1;
    else
      chop_start <= 1'b1;
    @(posedge clk);
    mod_tick <= 1'b0;
    chop_start <= 1'b0;
    @(negedge clk);
  endtask

  task automatic t_reset;
    rd(7'h14, 32'h0000);
    rd(7'h18, 32'h0600);
    rd(7'h1c, 32'h0000);
    rd(7'h20, 32'h0000);
    chk(32'(cfg), 32'h0600, "cfg at reset");
    chk({8'h00, threshold}, 32'h0, "threshold at reset");
    chk({31'h0, irq}, 32'h0, "irq at reset");
    $display("test reset done");
  endtask

  task automatic t_fields;
    logic [15:0] v;
    for (int k = 0; k < 16; k++)
    begin
      v = {3'h0, 4'(k), k[0], k[1], 3'(k), 3'(k) ^ 3'h5, 1'b0};
      wr(7'h18, v);
      rd(7'h18, {16'h0000, v});
      chk(32'(cfg), {19'h0, v[12:0]}, "cfg fields");
    end
    wr(7'h18, 16'h0600);
    $display("test fields done");
  endtask

  task automatic t_thresh;
    logic [31:0] q;
    wr(7'h1c, 16'h1234);
    wr(7'h20, 16'hffff);
    rd(7'h1c, 32'h1234);
    rd(7'h20, 32'hff0f);
    chk({8'h00, threshold}, 32'h1234ff, "joined threshold");
    chk({28'h0, dc_block}, 32'hf, "dc block");
    bus(1'b1, 7'h1c, 16'hbeef, 4'h0, q);
    rd(7'h1c, 32'h1234);
    bus(1'b1, 7'h1c, 16'hbeef, 4'h1, q);
    rd(7'h1c, 32'h12ef);
    wr(7'h7c, 16'h5555);
    rd(7'h7c, 32'h0);
    $display("test threshold done");
  endtask

  // Mode is cycled off and on between cases so each starts a fresh window
  task automatic t_detect;
    wr(7'h1c, 16'h0000);
    wr(7'h20, 16'h1000);
    wr(7'h44, 16'h0001);
    wr(7'h18, 16'h0601);
    samp(24'd16, 24'd0, 1'b0);
    samp(24'd0, 24'hffffef, 1'b1);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(7'h40, 32'h1);
    wr(7'h40, 16'h0001);
    rd(7'h40, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(7'h18, 16'h0600);
    samp(24'd17, 24'd17, 1'b0);
    wr(7'h18, 16'h0681);
    samp(24'd17, 24'd0, 1'b0);
    samp(24'd17, 24'd17, 1'b1);
    wr(7'h44, 16'h0000);
    wr(7'h18, 16'h0600);
    wr(7'h18, 16'h0621);
    repeat (3) samp(24'd17, 24'd0, 1'b0);
    samp(24'd0, 24'd17, 1'b1);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd(7'h40, 32'h1);
    wr(7'h40, 16'h0001);
    wr(7'h18, 16'h0600);
    wr(7'h18, 16'h0611);
    samp(24'd17, 24'd0, 1'b0);
    repeat (127) samp(24'd0, 24'd0, 1'b0);
    samp(24'd17, 24'd0, 1'b0);
    samp(24'd17, 24'd0, 1'b1);
    wr(7'h18, 16'h0600);
    $display("test detect done");
  endtask

  // A clear that lands with a new detection must keep the status bit
  task automatic t_set_wins;
    int n;
    n = 0;
    wr(7'h40, 16'h0001);
    wr(7'h18, 16'h0611);
    @(posedge clk);
    address <= 7'h40;
    write <= 1'b1;
    writedata <= 32'h0000_0001;
    byteenable <= 4'hf;
    sample_valid <= 1'b1;
    sample[0] <= 24'd17;
    sample[1] <= 24'd0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 100);
    chk({31'h0, waitrequest}, 32'h0, "clear answer");
    write <= 1'b0;
    sample_valid <= 1'b0;
    rd(7'h40, 32'h1);
    wr(7'h40, 16'h0001);
    wr(7'h18, 16'h0600);
    $display("test set wins done");
  endtask

  task automatic t_chop;
    wr(7'h40, 16'h0003);
    wr(7'h18, 16'h0100);
    pulse(1'b0);
    chk({31'h0, chop_settling}, 32'h1, "settle start");
    pulse(1'b1);
    chk({31'h0, chop_settling}, 32'h1, "settle one tick");
    pulse(1'b1);
    chk({31'h0, chop_settling}, 32'h0, "settle two ticks");
    rd(7'h40, 32'h2);
    wr(7'h40, 16'h0002);
    wr(7'h18, 16'h0700);
    pulse(1'b0);
    repeat (15) pulse(1'b1);
    chk({31'h0, chop_settling}, 32'h1, "settle 15 ticks");
    pulse(1'b1);
    chk({31'h0, chop_settling}, 32'h0, "settle 16 ticks");
    wr(7'h18, 16'h0600);
    $display("test chop done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    address = 7'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
    mod_tick = 1'b0;
    chop_start = 1'b0;
    sample_valid = 1'b0;
    sample = '0;
    miscompares = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_fields;
    t_thresh;
    t_detect;
    t_set_wins;
    t_chop;
    final_report;
  end

  // About 554 cycles are expected; allow ample margin
  initial
  begin
    #250000;
    miscompares++;
    final_report;
  end
endmodule
